// *** bit_sync.sv ***
`timescale 1ns/1ns
module bit_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic clk_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    meta_r <= d_i;
    q_o <= meta_r;
  end
endmodule : bit_sync

// *** jtag_bscan.sv ***
// Operation
// - instruction register is four bits, up to sixteen codes
// - every shift register moves its least significant bit first
// - id bits 31..28 hold the revision, zero for first silicon
// - id bits 27..12 hold a fixed part code
// - id bits 11..1 hold a maker code, bit 0 always one
// - code 0 selects boundary chain; capture pins, shift, update drives pins
// - loading code 0 drives the output latches onto pins at once
// - code 1 selects the id register; it is the power-up instruction
// - sample/preload captures and shifts; update only loads latches
// - code C selects one-bit reset register, shifted only, tap untouched
// - a one in the reset register holds the chip in reset
// - reset follows the register unlatched, then a time-out stretch
// - no high-impedance instruction; chip reset tristates the port pins except while extest is loaded
// - code F selects bypass stage; capture loads zero
// - control bit 7 set disables the test port, clear enables with fuse
// - disable bit changes only after two equal writes within four cycles
// - status bit 4 marks test reset; cleared by reset or written zero
// - each port pin has a pull-up cell and a two-stage drive cell
// - two-wire pins carry an extra cell for the two-wire driver enable
// - reset pin has two observe-only cells, low and high voltage
`timescale 1ns/1ns
module jtag_bscan #(
  parameter int PIN_W = 8,
  parameter int RESET_TIMEOUT_CYCLES = jtag_bscan_pkg::RESET_TIMEOUT_DEF,
  parameter logic [3:0] ID_VERSION = jtag_bscan_pkg::ID_VERSION_DEF,
  parameter logic [15:0] ID_PART = jtag_bscan_pkg::ID_PART_DEF,
  parameter logic [10:0] ID_MFR = jtag_bscan_pkg::ID_MFR_DEF
) (
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // test link
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic test_port_enable_fuse_i,
  // control and status register port
  input wire logic csr_wr_i,
  input wire logic [jtag_bscan_pkg::CSR_W-1:0] csr_wdata_i,
  output logic [jtag_bscan_pkg::CSR_W-1:0] csr_rdata_o,
  // core port logic
  input wire logic [PIN_W-1:0] port_output_bit_i,
  input wire logic [PIN_W-1:0] direction_bit_i,
  input wire logic global_pullup_disable_i,
  input wire logic [jtag_bscan_pkg::TWI_PINS-1:0] two_wire_driver_enable_i,
  // pads
  input wire logic [PIN_W-1:0] pin_value_i,
  input wire logic reset_pin_low_voltage_i,
  input wire logic reset_pin_high_voltage_i,
  output logic [PIN_W-1:0] pad_out_o,
  output logic [PIN_W-1:0] pad_oe_o,
  output logic [PIN_W-1:0] pad_pullup_o,
  output logic [jtag_bscan_pkg::TWI_PINS-1:0] pad_two_wire_oe_o,
  // chip reset
  output logic chip_reset_o,
  output logic core_reset_o
);
  import jtag_bscan_pkg::*;

  localparam int CHAIN_LEN = CELLS_PER_PIN * PIN_W + EXTRA_CELLS;
  localparam int TWI_BASE = CELLS_PER_PIN * PIN_W;
  localparam int CORE_W = 2 * PIN_W + 1 + TWI_PINS;
  localparam int PAD_W = PIN_W + 2;

  // ****************************************
  // link domain crossings
  // ****************************************
  logic disable_r;
  logic [2:0] ctl_t;
  logic [CORE_W-1:0] core_t;
  logic [PAD_W-1:0] pad_t;
  logic tap_rst;

  bit_sync #(.W(3)) u_ctl_sync (
    .clk_i(tck_i),
    .d_i({reset_i, test_port_enable_fuse_i, disable_r}),
    .q_o(ctl_t)
  );
  bit_sync #(.W(CORE_W)) u_core_sync (
    .clk_i(tck_i),
    .d_i({two_wire_driver_enable_i, global_pullup_disable_i, direction_bit_i,
          port_output_bit_i}),
    .q_o(core_t)
  );
  bit_sync #(.W(PAD_W)) u_pad_sync (
    .clk_i(tck_i),
    .d_i({reset_pin_high_voltage_i, reset_pin_low_voltage_i, pin_value_i}),
    .q_o(pad_t)
  );

  // port held in test-logic-reset during reset, and unless fuse set and disable bit clear
  assign tap_rst = ctl_t[2] | ~(ctl_t[1] & ~ctl_t[0]);

  // ****************************************
  // tap controller
  // ****************************************
  tap_state_t state;

  tap_fsm u_tap (
    .clk_tck_i(tck_i),
    .reset_i(tap_rst),
    .tms_i(tms_i),
    .state_o(state)
  );

  logic cap_dr;
  logic sh_dr;
  logic upd_dr;
  assign cap_dr = (state == ST_CAP_DR);
  assign sh_dr = (state == ST_SH_DR);
  assign upd_dr = (state == ST_UPD_DR);

  // ****************************************
  // instruction register
  // ****************************************
  logic [IR_W-1:0] ir_sh_r;
  logic [IR_W-1:0] ir_r;
  logic extest_t_r;

  always_ff @(posedge tck_i) begin
    if (tap_rst || state == ST_TLR) begin
      ir_sh_r <= IR_CAPTURE;
      ir_r <= OP_IDCODE;
      extest_t_r <= 1'b0;
    end else if (state == ST_CAP_IR) begin
      ir_sh_r <= IR_CAPTURE;
    end else if (state == ST_SH_IR) begin
      ir_sh_r <= {tdi_i, ir_sh_r[IR_W-1:1]};
    end else if (state == ST_UPD_IR) begin
      ir_r <= ir_sh_r;
      extest_t_r <= (ir_sh_r == OP_EXTEST);
    end
  end

  // ****************************************
  // bypass, identification and reset registers
  // ****************************************
  logic byp_r;
  logic [ID_W-1:0] id_sh_r;
  logic [ID_W-1:0] id_value;
  assign id_value = {ID_VERSION, ID_PART, ID_MFR, ID_MARKER};

  always_ff @(posedge tck_i) begin
    if (cap_dr && ir_r == OP_IDCODE) begin
      id_sh_r <= id_value;
    end else if (sh_dr && ir_r == OP_IDCODE) begin
      id_sh_r <= {tdi_i, id_sh_r[ID_W-1:1]};
    end
  end

  always_ff @(posedge tck_i) begin
    if (cap_dr) begin
      byp_r <= 1'b0;
    end else if (sh_dr) begin
      byp_r <= tdi_i;
    end
  end

  // unlatched: the shift stage itself is the reset source
  always_ff @(posedge tck_i) begin
    if (tap_rst) begin
      chip_reset_o <= 1'b0;
    end else if (sh_dr && ir_r == OP_CHIP_RESET) begin
      chip_reset_o <= tdi_i;
    end
  end

  // ****************************************
  // boundary chain
  // ****************************************
  logic [CHAIN_LEN-1:0] cap_vec;
  logic [CHAIN_LEN-1:0] chain_r;
  logic [CHAIN_LEN-1:0] upd_r;
  logic scan_sel;
  assign scan_sel = (ir_r == OP_EXTEST) || (ir_r == OP_SAMPLE);

  for (genvar i = 0; i < PIN_W; i++) begin : g_pin_cap
    // pull-up enable = not global disable, not output, port bit high
    assign cap_vec[CELLS_PER_PIN*i+CELL_PUE] =
        ~core_t[2*PIN_W] & ~core_t[PIN_W+i] & core_t[i];
    assign cap_vec[CELLS_PER_PIN*i+CELL_OC] = core_t[PIN_W+i];
    assign cap_vec[CELLS_PER_PIN*i+CELL_ODID] = pad_t[i];
  end
  for (genvar k = 0; k < TWI_PINS; k++) begin : g_twi_cap
    assign cap_vec[TWI_BASE+k] = core_t[2*PIN_W+1+k];
  end
  assign cap_vec[TWI_BASE+CELL_LOW_VOLTAGE_RESET_OBSERVE_OFS] = pad_t[PIN_W];
  assign cap_vec[TWI_BASE+CELL_HIGH_VOLTAGE_RESET_OBSERVE_OFS] = pad_t[PIN_W+1];

  always_ff @(posedge tck_i) begin
    if (cap_dr && scan_sel) begin
      chain_r <= cap_vec;
    end else if (sh_dr && scan_sel) begin
      chain_r <= {tdi_i, chain_r[CHAIN_LEN-1:1]};
    end
  end

  // observe-only cells are latched too but never read on the pad side
  always_ff @(posedge tck_i) begin
    if (tap_rst) begin
      upd_r <= '0;
    end else if (upd_dr && scan_sel) begin
      upd_r <= chain_r;
    end
  end

  // ****************************************
  // test data out, falling edge
  // ****************************************
  logic dr_out;

  always_comb begin
    case (ir_r)
      OP_EXTEST, OP_SAMPLE: dr_out = chain_r[0];
      OP_IDCODE: dr_out = id_sh_r[0];
      OP_CHIP_RESET: dr_out = chip_reset_o;
      default: dr_out = byp_r; // unused codes fall to bypass
    endcase
  end

  always_ff @(negedge tck_i) begin
    if (tap_rst) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      tdo_o <= (state == ST_SH_IR) ? ir_sh_r[0] : dr_out;
      tdo_oe_o <= (state == ST_SH_IR) || sh_dr;
    end
  end

  // ****************************************
  // system domain crossings
  // ****************************************
  // latch word is quasi-static: it only moves on update or port reset, so it
  // crosses by per-bit sync and a settle filter, not a handshake
  logic [CHAIN_LEN+1:0] tck_s;
  logic [CHAIN_LEN-1:0] upd_s;
  logic extest_s;
  logic rst_req_s;

  bit_sync #(.W(CHAIN_LEN+2)) u_sys_sync (
    .clk_i(clk_sys_i),
    .d_i({chip_reset_o, extest_t_r, upd_r}),
    .q_o(tck_s)
  );
  assign upd_s = tck_s[CHAIN_LEN-1:0];
  assign extest_s = tck_s[CHAIN_LEN];
  assign rst_req_s = tck_s[CHAIN_LEN+1];

  // per-bit sync may skew by a cycle; only a word seen twice alike is used
  logic [CHAIN_LEN-1:0] upd_d_r;
  logic [CHAIN_LEN-1:0] upd_hold_r;

  always_ff @(posedge clk_sys_i) begin
    upd_d_r <= upd_s;
    if (reset_i) begin
      upd_hold_r <= '0;
    end else if (upd_s == upd_d_r) begin
      upd_hold_r <= upd_s;
    end
  end

  // ****************************************
  // chip reset stretch
  // ****************************************
  logic [15:0] tmo_r;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      tmo_r <= 16'h0000;
    end else if (rst_req_s) begin
      tmo_r <= 16'(RESET_TIMEOUT_CYCLES);
    end else if (tmo_r != 16'h0000) begin
      tmo_r <= tmo_r - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      core_reset_o <= 1'b0;
    end else begin
      core_reset_o <= rst_req_s || (tmo_r != 16'h0000);
    end
  end

  // ****************************************
  // pad drivers
  // ****************************************
  for (genvar i = 0; i < PIN_W; i++) begin : g_pad
    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        pad_out_o[i] <= 1'b0;
        pad_oe_o[i] <= 1'b0;
        pad_pullup_o[i] <= 1'b0;
      end else if (extest_s) begin
        pad_out_o[i] <= upd_hold_r[CELLS_PER_PIN*i+CELL_ODID];
        pad_oe_o[i] <= upd_hold_r[CELLS_PER_PIN*i+CELL_OC];
        pad_pullup_o[i] <= upd_hold_r[CELLS_PER_PIN*i+CELL_PUE];
      end else if (core_reset_o) begin
        pad_out_o[i] <= 1'b0;
        pad_oe_o[i] <= 1'b0;
        pad_pullup_o[i] <= 1'b0;
      end else begin
        pad_out_o[i] <= port_output_bit_i[i];
        pad_oe_o[i] <= direction_bit_i[i];
        pad_pullup_o[i] <= ~global_pullup_disable_i & ~direction_bit_i[i] &
                           port_output_bit_i[i];
      end
    end
  end

  // contention between output control and two-wire enable is the controller's care
  for (genvar k = 0; k < TWI_PINS; k++) begin : g_twi
    always_ff @(posedge clk_sys_i) begin
      if (reset_i || (!extest_s && core_reset_o)) begin
        pad_two_wire_oe_o[k] <= 1'b0;
      end else if (extest_s) begin
        pad_two_wire_oe_o[k] <= upd_hold_r[TWI_BASE+k];
      end else begin
        pad_two_wire_oe_o[k] <= two_wire_driver_enable_i[k];
      end
    end
  end

  // ****************************************
  // control and status register
  // ****************************************
  logic arm_val_r;
  logic [2:0] arm_cnt_r;
  logic flag_r;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      disable_r <= 1'b0;
      arm_val_r <= 1'b0;
      arm_cnt_r <= 3'h0;
    end else if (csr_wr_i) begin
      if (arm_cnt_r != 3'h0 && csr_wdata_i[CSR_DISABLE_BIT] == arm_val_r) begin
        disable_r <= arm_val_r;
        arm_cnt_r <= 3'h0;
      end else begin
        arm_val_r <= csr_wdata_i[CSR_DISABLE_BIT];
        arm_cnt_r <= DISABLE_WINDOW;
      end
    end else if (arm_cnt_r != 3'h0) begin
      arm_cnt_r <= arm_cnt_r - 3'h1;
    end
  end

  // a reset request in the clearing cycle wins
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      flag_r <= 1'b0;
    end else if (rst_req_s) begin
      flag_r <= 1'b1;
    end else if (csr_wr_i && !csr_wdata_i[CSR_FLAG_BIT]) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      csr_rdata_o <= '0;
    end else begin
      csr_rdata_o <= '0;
      csr_rdata_o[CSR_DISABLE_BIT] <= disable_r;
      csr_rdata_o[CSR_FLAG_BIT] <= flag_r;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_ir_default: assert property (@(posedge tck_i) disable iff (tap_rst)
      state == ST_TLR |=> ir_r == OP_IDCODE)
    else $error("instruction not idcode after test-logic-reset");
  a_id_version: assert property (@(posedge tck_i) disable iff (tap_rst)
      cap_dr && ir_r == OP_IDCODE |=> id_sh_r[ID_W-1:ID_VER_LSB] == ID_VERSION)
    else $error("id version field wrong");
  a_id_part: assert property (@(posedge tck_i) disable iff (tap_rst)
      cap_dr && ir_r == OP_IDCODE |=> id_sh_r[ID_VER_LSB-1:ID_PART_LSB] == ID_PART)
    else $error("id part field wrong");
  a_id_marker: assert property (@(posedge tck_i) disable iff (tap_rst)
      cap_dr && ir_r == OP_IDCODE |=> id_sh_r[0] && id_sh_r[ID_PART_LSB-1:ID_MFR_LSB] == ID_MFR)
    else $error("id maker field or marker wrong");
  a_ir_lsb_first: assert property (@(posedge tck_i) disable iff (tap_rst)
      state == ST_SH_IR |=> ir_sh_r == {$past(tdi_i), $past(ir_sh_r[IR_W-1:1])})
    else $error("instruction shift order wrong");
  a_bypass_zero: assert property (@(posedge tck_i) disable iff (tap_rst)
      cap_dr && ir_r == OP_BYPASS |=> !byp_r)
    else $error("bypass capture not zero");
  a_reset_shift: assert property (@(posedge tck_i) disable iff (tap_rst)
      sh_dr && ir_r == OP_CHIP_RESET ##1 ir_r == OP_CHIP_RESET |-> chip_reset_o == $past(tdi_i))
    else $error("reset register does not follow tdi");
  a_reset_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      rst_req_s |=> core_reset_o [*1] ##1 core_reset_o)
    else $error("core reset not held while requested");
  a_flag_set: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      rst_req_s |=> flag_r)
    else $error("test reset flag not set");
  a_single_write: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      csr_wr_i && arm_cnt_r == 3'h0 |=> $stable(disable_r))
    else $error("disable bit changed on a single write");
  a_extest_drive: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      extest_s |=> pad_oe_o[0] == $past(upd_hold_r[CELL_OC]))
    else $error("extest latches not driven on pins");

  c_extest: cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(extest_s));
  c_chip_reset: cover property (@(posedge clk_sys_i) disable iff (reset_i) $fell(core_reset_o));
  c_disable: cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(disable_r));
endmodule : jtag_bscan

// *** jtag_bscan_pkg.sv ***
package jtag_bscan_pkg;

  // ****************************************
  // instruction register
  // ****************************************
  localparam int IR_W = 4;
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_IDCODE = 4'h1;
  localparam logic [3:0] OP_SAMPLE = 4'h2;
  localparam logic [3:0] OP_CHIP_RESET = 4'hC;
  localparam logic [3:0] OP_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // ****************************************
  // identification register
  // ****************************************
  localparam int ID_W = 32;
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  localparam logic ID_MARKER = 1'b1;
  // arbitrary neutral identity values
  localparam logic [3:0] ID_VERSION_DEF = 4'h0;
  localparam logic [15:0] ID_PART_DEF = 16'h1234;
  localparam logic [10:0] ID_MFR_DEF = 11'h055;

  // ****************************************
  // boundary chain layout
  // ****************************************
  localparam int CELLS_PER_PIN = 3;
  localparam int CELL_PUE = 0;
  localparam int CELL_OC = 1;
  localparam int CELL_ODID = 2;
  localparam int TWI_PINS = 2;
  localparam int EXTRA_CELLS = 4;
  localparam int CELL_LOW_VOLTAGE_RESET_OBSERVE_OFS = 2;
  localparam int CELL_HIGH_VOLTAGE_RESET_OBSERVE_OFS = 3;

  // ****************************************
  // control and status register
  // ****************************************
  localparam int CSR_W = 8;
  localparam int CSR_DISABLE_BIT = 7;
  localparam int CSR_FLAG_BIT = 4;
  localparam logic [2:0] DISABLE_WINDOW = 3'h4;
  localparam int RESET_TIMEOUT_DEF = 16;

  // ****************************************
  // test access port states
  // ****************************************
  typedef enum logic [3:0] {
    ST_TLR = 4'h0,
    ST_RTI = 4'h1,
    ST_SEL_DR = 4'h3,
    ST_CAP_DR = 4'h2,
    ST_SH_DR = 4'h6,
    ST_EX1_DR = 4'h7,
    ST_PAU_DR = 4'h5,
    ST_EX2_DR = 4'h4,
    ST_UPD_DR = 4'hC,
    ST_SEL_IR = 4'hD,
    ST_CAP_IR = 4'hF,
    ST_SH_IR = 4'hE,
    ST_EX1_IR = 4'hA,
    ST_PAU_IR = 4'hB,
    ST_EX2_IR = 4'h9,
    ST_UPD_IR = 4'h8
  } tap_state_t;

endpackage : jtag_bscan_pkg

// *** jtag_ctl_model.sv ***
`timescale 1ns/1ns
module jtag_ctl_model (
  // test link
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  logic oe_seen = 1'b0;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // ****************************************
  // one link cycle: tck rests low between frames
  // ****************************************
  task automatic step(input logic m, input logic d, output logic o);
    tms_o = m;
    tdi_o = d;
    #32;
    o = tdo_i;
    oe_seen = oe_seen | tdo_oe_i;
    tck_o = 1'b1;
    #32;
    tck_o = 1'b0;
  endtask : step
  task automatic tlr();
    logic o;
    repeat (6) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : tlr
  // ****************************************
  // ir or dr scan from idle back to idle
  // ****************************************
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    oe_seen = 1'b0;
    // two idle edges let the captured core levels settle through the sync
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, ~din[n-1], o);
    step(1'b0, din[n-1], o);
  endtask : scan
endmodule : jtag_ctl_model

// *** tap_fsm.sv ***
`timescale 1ns/1ns
module tap_fsm (
  // link clock and reset
  input wire logic clk_tck_i,
  input wire logic reset_i,
  // mode select
  input wire logic tms_i,
  output jtag_bscan_pkg::tap_state_t state_o
);
  import jtag_bscan_pkg::*;

  tap_state_t state_nxt;

  always_comb begin
    state_nxt = state_o;
    case (state_o)
      ST_TLR: state_nxt = tms_i ? ST_TLR : ST_RTI;
      ST_RTI: state_nxt = tms_i ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_nxt = tms_i ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_nxt = tms_i ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_nxt = tms_i ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_nxt = tms_i ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_nxt = tms_i ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_nxt = tms_i ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_nxt = tms_i ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_nxt = tms_i ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: state_nxt = tms_i ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_nxt = tms_i ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_nxt = tms_i ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_nxt = tms_i ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_nxt = tms_i ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_nxt = tms_i ? ST_SEL_DR : ST_RTI;
      default: state_nxt = ST_TLR;
    endcase
  end

  always_ff @(posedge clk_tck_i) begin
    if (reset_i) begin
      state_o <= ST_TLR;
    end else begin
      state_o <= state_nxt;
    end
  end
endmodule : tap_fsm

// *** tb.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
  import jtag_bscan_pkg::*;
  localparam int TO = 4;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, chip_reset, core_reset;
  logic csr_wr = 1'b0;
  logic global_pullup_disable = 1'b0;
  logic fuse = 1'b1;
  logic rst_lv = 1'b1;
  logic rst_hv = 1'b0;
  logic [7:0] csr_wdata = 8'h00;
  logic [7:0] csr_rdata;
  logic [1:0] port_bit = 2'b00;
  logic [1:0] dir_bit = 2'b00;
  logic [1:0] twe = 2'b00;
  logic [1:0] pin_val = 2'b00;
  logic [1:0] pad_out, pad_oe, pad_pu, pad_tw;
  logic [31:0] d;
  int fails = 0;
  int n_checks = 0;
  int tail = 0;
  jtag_bscan #(.PIN_W(2), .RESET_TIMEOUT_CYCLES(TO)) jtag_bscan_inst (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .test_port_enable_fuse_i(fuse), .csr_wr_i(csr_wr),
    .csr_wdata_i(csr_wdata), .csr_rdata_o(csr_rdata), .port_output_bit_i(port_bit),
    .direction_bit_i(dir_bit), .global_pullup_disable_i(global_pullup_disable),
    .two_wire_driver_enable_i(twe), .pin_value_i(pin_val),
    .reset_pin_low_voltage_i(rst_lv), .reset_pin_high_voltage_i(rst_hv),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pad_pullup_o(pad_pu),
    .pad_two_wire_oe_o(pad_tw), .chip_reset_o(chip_reset), .core_reset_o(core_reset));
  jtag_ctl_model jtag_ctl_model_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
    .tdo_oe_i(tdo_oe));
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // stretch length seen after the link reset drops
  always @(posedge clk_sys_i) begin
    if (chip_reset) tail <= 0;
    else if (core_reset) tail <= tail + 1;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : wait_clk
  task automatic csr_put(input logic [7:0] v);
    @(posedge clk_sys_i);
    #1;
    csr_wr = 1'b1;
    csr_wdata = v;
    @(posedge clk_sys_i);
    #1;
    csr_wr = 1'b0;
  endtask : csr_put
  task automatic sc(input logic ir, input int n, input logic [31:0] v);
    jtag_ctl_model_inst.scan(ir, n, v, d);
    if (ir) `CHK("ir capture", IR_CAPTURE, d[3:0])
  endtask : sc
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_idcode();
    `CHK("csr reset", 8'h00, csr_rdata)
    sc(1'b0, 32, 32'h0);
    `CHK("idcode", {ID_VERSION_DEF, ID_PART_DEF, ID_MFR_DEF, 1'b1}, d)
    `CHK("tdo enable", 1'b1, jtag_ctl_model_inst.oe_seen)
  endtask : test_idcode
  task automatic test_sample();
    @(posedge clk_sys_i);
    #1;
    port_bit = 2'b10;
    dir_bit = 2'b01;
    pin_val = 2'b01;
    twe = 2'b10;
    sc(1'b1, 4, {28'h0, OP_SAMPLE});
    // preload keeps output control and two-wire enable apart
    sc(1'b0, 10, 32'h0000_001E);
    `CHK("sample capture", 10'h18E, d[9:0])
    wait_clk(8);
    `CHK("sample pads", 2'b01, pad_oe)
  endtask : test_sample
  task automatic test_extest();
    sc(1'b1, 4, {28'h0, OP_EXTEST});
    wait_clk(6);
    `CHK("extest pads", 6'b10_1101, {pad_pu, pad_oe, pad_out})
    `CHK("extest two wire", 2'b00, pad_tw)
    sc(1'b0, 10, 32'h0000_0022);
    wait_clk(6);
    `CHK("extest update", 6'b00_0110, {pad_pu, pad_oe, pad_out})
  endtask : test_extest
  task automatic test_bypass();
    sc(1'b1, 4, {28'h0, OP_BYPASS});
    sc(1'b0, 8, 32'h0000_00A5);
    `CHK("bypass", 8'h4A, d[7:0])
    // an undefined code must still give a one-stage path
    sc(1'b1, 4, 32'h0000_0005);
    sc(1'b0, 8, 32'h0000_00A5);
    `CHK("unused code", 8'h4A, d[7:0])
    wait_clk(8);
    `CHK("normal pads", 2'b01, pad_oe)
  endtask : test_bypass
  task automatic test_chip_reset();
    sc(1'b1, 4, {28'h0, OP_CHIP_RESET});
    sc(1'b0, 1, 32'h1);
    `CHK("reset reg", 1'b1, chip_reset)
    wait_clk(6);
    `CHK("core reset", 1'b1, core_reset)
    `CHK("reset pads", 2'b00, pad_oe)
    `CHK("flag set", 1'b1, csr_rdata[CSR_FLAG_BIT])
    sc(1'b0, 1, 32'h0);
    `CHK("reset drop", 1'b0, chip_reset)
    `CHK("stretch", 1'b1, tail >= TO && tail <= TO + 4)
    `CHK("flag kept", 1'b1, csr_rdata[CSR_FLAG_BIT])
    csr_put(8'h00);
    wait_clk(2);
    `CHK("flag clear", 1'b0, csr_rdata[CSR_FLAG_BIT])
  endtask : test_chip_reset
  task automatic test_disable();
    csr_put(8'h80);
    wait_clk(8);
    `CHK("single write", 8'h00, csr_rdata)
    // an unconnected port is parked disabled to keep tdo quiet
    csr_put(8'h80);
    csr_put(8'h80);
    wait_clk(2);
    `CHK("double write", 8'h80, csr_rdata)
    sc(1'b0, 4, 32'h0);
    `CHK("port off", 1'b0, jtag_ctl_model_inst.oe_seen)
    csr_put(8'h00);
    csr_put(8'h00);
    wait_clk(2);
    // disable bit clear but fuse unprogrammed still keeps the port off
    fuse = 1'b0;
    sc(1'b0, 4, 32'h0);
    `CHK("fuse off", 1'b0, jtag_ctl_model_inst.oe_seen)
    fuse = 1'b1;
    // the tap sat in test-logic-reset, so walk it back to idle first
    jtag_ctl_model_inst.tlr();
    sc(1'b1, 4, {28'h0, OP_IDCODE});
    `CHK("port on", 1'b1, jtag_ctl_model_inst.oe_seen)
  endtask : test_disable
  initial begin
    #100_000;
    fails++;
    test_done();
  end
  initial begin
    wait_clk(6);
    // the link side needs tck edges to see the reset
    jtag_ctl_model_inst.tlr();
    @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
    jtag_ctl_model_inst.tlr();
    test_idcode();
    test_sample();
    test_extest();
    test_bypass();
    test_chip_reset();
    test_disable();
    test_done();
  end
endmodule : tb
